// ===== verilog/tsr_params.svh
// constants for the temperature sensor register block
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

// register selector codes
`define TSR_SEL_TEMP 2'h0
`define TSR_SEL_CFG 2'h1
`define TSR_SEL_LOW 2'h2
`define TSR_SEL_HIGH 2'h3
`define TSR_PTR_RST 2'h0

// configuration byte one bit positions
`define TSR_B0_OS 7
`define TSR_B0_FQ_HI 4
`define TSR_B0_FQ_LO 3
`define TSR_B0_POL 2
`define TSR_B0_TM 1
`define TSR_B0_SD 0
// configuration byte two bit positions
`define TSR_B1_CR_HI 7
`define TSR_B1_CR_LO 6
`define TSR_B1_EM 4

// reset values
`define TSR_RES_VAL 2'h3
`define TSR_FQ_RST 2'h0
`define TSR_POL_RST 1'b0
`define TSR_TM_RST 1'b0
`define TSR_SD_RST 1'b0
`define TSR_CR_RST 2'h2
`define TSR_EM_RST 1'b0
`define TSR_HIGH_RST 16'h5000
`define TSR_LOW_RST 16'h4b00
`define TSR_TEMP_RST 13'h0000

// data format details
`define TSR_NORM_MASK 8'hf0
`define TSR_EXT_MASK 8'hf8
`define TSR_NORM_PAD 4'h0
`define TSR_EXT_PAD 3'h1
`define TSR_CFG_PAD 4'h0

// consecutive faults per fault queue code
`define TSR_FQ_N0 3'h1
`define TSR_FQ_N1 3'h2
`define TSR_FQ_N2 3'h4
`define TSR_FQ_N3 3'h6

// conversion periods in ms and the core clock in kHz
`define TSR_CLK_KHZ 100000
`define TSR_RATE0_MS 4000
`define TSR_RATE1_MS 1000
`define TSR_RATE2_MS 250
`define TSR_RATE3_MS 125

`endif

// ===== verilog/tsr_pkg.sv
// types shared by the temperature sensor register block
package tsr_pkg;
  typedef enum logic [1:0] {TSR_OP_WR, TSR_OP_RD, TSR_OP_GC, TSR_OP_ARA} tsr_op_t;
  typedef enum logic [1:0] {TSR_ST_IDLE, TSR_ST_CONV, TSR_ST_WAIT} tsr_st_t;
  typedef struct packed {
    tsr_op_t op;
    logic [1:0] sel;
    logic idx;
    logic [7:0] data;
  } tsr_cmd_t;
endpackage : tsr_pkg

// ===== verilog/tsr_cmd_if.sv
// command and answer channel between link front end and core
`timescale 1ns/100ps
interface tsr_cmd_if;
  import tsr_pkg::*;
  logic cmd_send;
  tsr_cmd_t cmd_word;
  logic cmd_busy;
  logic ans_valid;
  logic [7:0] ans_byte;
  modport link (output cmd_send, output cmd_word, input cmd_busy,
                input ans_valid, input ans_byte);
  modport core (input cmd_send, input cmd_word, output cmd_busy,
                output ans_valid, output ans_byte);
endinterface : tsr_cmd_if

// ===== verilog/tsr_xfer.sv
// toggle handshake that carries one word between two clock domains
`timescale 1ns/100ps
module tsr_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk_in, // source clock
  input wire logic src_rst_in, // async reset, high
  input wire logic send_in, // take data when not busy
  input wire logic [W-1:0] data_in, // word to carry
  output logic busy_out, // word in flight
  input wire logic dst_clk_in, // destination clock
  input wire logic dst_rst_in, // async reset, high
  output logic valid_out, // one-cycle arrival pulse
  output logic [W-1:0] data_out // arrived word
);
  logic req_reg, ack_s1_reg, ack_s2_reg;
  logic req_s1_reg, req_s2_reg, req_s3_reg, ack_reg;
  logic [W-1:0] hold_reg;

  ////////////////////////////////////////////////////////////////////////
  // source side: hold stays still while busy so the far side reads it safe
  always_ff @(posedge src_clk_in or posedge src_rst_in) begin
    if (src_rst_in) begin
      req_reg <= 1'b0;
      hold_reg <= '0;
    end else if (send_in && !busy_out) begin
      req_reg <= ~req_reg;
      hold_reg <= data_in;
    end
  end

  always_ff @(posedge src_clk_in or posedge src_rst_in) begin
    if (src_rst_in) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  assign busy_out = req_reg ^ ack_s2_reg;

  ////////////////////////////////////////////////////////////////////////
  // destination side: edge taken from second and third stage only
  always_ff @(posedge dst_clk_in or posedge dst_rst_in) begin
    if (dst_rst_in) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      ack_reg <= 1'b0;
      valid_out <= 1'b0;
      data_out <= '0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      ack_reg <= req_s2_reg;
      valid_out <= req_s2_reg ^ req_s3_reg;
      if (req_s2_reg ^ req_s3_reg) begin
        data_out <= hold_reg;
      end
    end
  end
endmodule : tsr_xfer

// ===== verilog/tsr_link.sv
// link-clock front end: selector, byte order and command issue
`timescale 1ns/100ps
module tsr_link (
  input wire logic link_clk_in, // link clock
  input wire logic rst_in, // async reset, high
  input wire logic start_in, // frame start, restarts byte order
  input wire logic ptr_wr_in, // byte is a selector write
  input wire logic wr_in, // byte is a data write
  input wire logic rd_in, // request next read byte
  input wire logic gc_in, // general-call reset received
  input wire logic ara_in, // alert response won
  input wire logic [7:0] data_in, // written byte
  output logic ready_out, // requests taken when high
  output logic [7:0] rd_data_out, // read byte
  output logic rd_valid_out, // read byte pulse
  tsr_cmd_if.link cmd // channel to core
);
  import tsr_pkg::*;
  `include "tsr_params.svh"

  logic [1:0] ptr_reg;
  logic idx_reg;
  logic rd_wait_reg;
  logic take;

  // a read holds off every request except frame start until its byte has come back
  assign ready_out = !(cmd.cmd_busy || rd_wait_reg);
  assign take = ready_out && (wr_in || rd_in || gc_in || ara_in);
  assign cmd.cmd_send = take;

  // command word, general call first
  always_comb begin
    cmd.cmd_word.op = gc_in ? TSR_OP_GC : ara_in ? TSR_OP_ARA :
                      wr_in ? TSR_OP_WR : TSR_OP_RD;
    cmd.cmd_word.sel = ptr_reg;
    cmd.cmd_word.idx = idx_reg;
    cmd.cmd_word.data = data_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // register selector: only the low two bits are kept
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_reg <= `TSR_PTR_RST;
    end else if (ready_out && gc_in) begin
      ptr_reg <= `TSR_PTR_RST;
    end else if (ready_out && ptr_wr_in) begin
      ptr_reg <= data_in[1:0];
    end
  end

  // byte order: most significant byte first, toggles per data byte
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_reg <= 1'b0;
    end else if (start_in || (ready_out && (ptr_wr_in || gc_in))) begin
      idx_reg <= 1'b0;
    end else if (ready_out && (wr_in || rd_in)) begin
      idx_reg <= ~idx_reg;
    end
  end

  // read byte return
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_wait_reg <= 1'b0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= cmd.ans_valid;
      if (cmd.ans_valid) begin
        rd_data_out <= cmd.ans_byte;
        rd_wait_reg <= 1'b0;
      end else if (take && rd_in && !gc_in && !ara_in && !wr_in) begin
        rd_wait_reg <= 1'b1;
      end
    end
  end
endmodule : tsr_link

// ===== verilog/tsr_core.sv
// temperature sensor registers, conversion pacing and thermostat output
`timescale 1ns/100ps
`include "tsr_params.svh"

module tsr_core #(
  parameter int unsigned PERIOD0 = `TSR_RATE0_MS * `TSR_CLK_KHZ,
  parameter int unsigned PERIOD1 = `TSR_RATE1_MS * `TSR_CLK_KHZ,
  parameter int unsigned PERIOD2 = `TSR_RATE2_MS * `TSR_CLK_KHZ,
  parameter int unsigned PERIOD3 = `TSR_RATE3_MS * `TSR_CLK_KHZ
) (
  input wire logic clock_in, // core clock, 100 MHz
  input wire logic rst_in, // async reset, high
  input wire logic link_clk_in, // bus engine clock
  input wire logic link_start_in, // frame start
  input wire logic link_ptr_wr_in, // selector byte
  input wire logic link_wr_in, // data byte write
  input wire logic link_rd_in, // data byte read request
  input wire logic link_gc_in, // general-call reset
  input wire logic link_ara_in, // alert response won
  input wire logic [7:0] link_data_in, // written byte
  output logic link_ready_out, // link requests taken
  output logic [7:0] link_rd_data_out, // read byte
  output logic link_rd_valid_out, // read byte pulse
  output logic conv_start_out, // start one conversion
  input wire logic conv_done_in, // conversion finished
  input wire logic [12:0] conv_data_in, // signed result
  output logic power_down_out, // converter idle in shutdown
  output logic alert_o_out, // threshold pin level
  output logic alert_oe_out // threshold pin pulled low
);
  import tsr_pkg::*;

  tsr_cmd_if cmd_bus ();
  tsr_cmd_t cmd_q;
  logic cmd_valid;

  // configuration and data registers
  logic [1:0] fq_reg, cr_reg;
  logic pol_reg, tm_reg, sd_reg, em_reg;
  logic [15:0] high_reg, low_reg;
  logic [12:0] temp_reg;
  logic os_pend_reg, os_done_reg;
  // conversion pacing
  tsr_st_t st_reg, st_next;
  logic [31:0] per_cnt_reg;
  logic [31:0] period;
  logic start_next;
  // thermostat
  logic [2:0] fcnt_reg;
  logic cmp_reg, int_reg, alert_oe_reg;
  logic [2:0] need;
  logic signed [12:0] tval, hval, lval;
  logic fault, flip;
  // answers
  logic ans_send_reg;
  logic [7:0] ans_byte_reg;
  // decoded events
  logic ev_wr, ev_rd, ev_gc, ev_ara, cfg0_wr, cfg1_wr, os_go, conv_end;
  logic al_bit, os_bit, active;
  logic [7:0] lim_mask;

  ////////////////////////////////////////////////////////////////////////
  // link side and the two crossings
  tsr_link u_link (
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .start_in(link_start_in),
    .ptr_wr_in(link_ptr_wr_in),
    .wr_in(link_wr_in),
    .rd_in(link_rd_in),
    .gc_in(link_gc_in),
    .ara_in(link_ara_in),
    .data_in(link_data_in),
    .ready_out(link_ready_out),
    .rd_data_out(link_rd_data_out),
    .rd_valid_out(link_rd_valid_out),
    .cmd(cmd_bus.link)
  );

  tsr_xfer #(.W($bits(tsr_cmd_t))) u_cmd_x (
    .src_clk_in(link_clk_in),
    .src_rst_in(rst_in),
    .send_in(cmd_bus.cmd_send),
    .data_in(cmd_bus.cmd_word),
    .busy_out(cmd_bus.cmd_busy),
    .dst_clk_in(clock_in),
    .dst_rst_in(rst_in),
    .valid_out(cmd_valid),
    .data_out(cmd_q)
  );

  // link waits for each read byte, so this crossing is never busy
  tsr_xfer #(.W(8)) u_ans_x (
    .src_clk_in(clock_in),
    .src_rst_in(rst_in),
    .send_in(ans_send_reg),
    .data_in(ans_byte_reg),
    .busy_out(),
    .dst_clk_in(link_clk_in),
    .dst_rst_in(rst_in),
    .valid_out(cmd_bus.ans_valid),
    .data_out(cmd_bus.ans_byte)
  );

  ////////////////////////////////////////////////////////////////////////
  // command decode
  assign ev_wr = cmd_valid && (cmd_q.op == TSR_OP_WR);
  assign ev_rd = cmd_valid && (cmd_q.op == TSR_OP_RD);
  assign ev_gc = cmd_valid && (cmd_q.op == TSR_OP_GC);
  assign ev_ara = cmd_valid && (cmd_q.op == TSR_OP_ARA);
  assign cfg0_wr = ev_wr && (cmd_q.sel == `TSR_SEL_CFG) && !cmd_q.idx;
  assign cfg1_wr = ev_wr && (cmd_q.sel == `TSR_SEL_CFG) && cmd_q.idx;
  // one-shot only counts when the write leaves the part shut down
  assign os_go = cfg0_wr && cmd_q.data[`TSR_B0_OS]
                 && cmd_q.data[`TSR_B0_SD];
  assign conv_end = (st_reg == TSR_ST_CONV) && conv_done_in;

  ////////////////////////////////////////////////////////////////////////
  // configuration register, updated one byte at a time
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fq_reg <= `TSR_FQ_RST;
      pol_reg <= `TSR_POL_RST;
      tm_reg <= `TSR_TM_RST;
      sd_reg <= `TSR_SD_RST;
      cr_reg <= `TSR_CR_RST;
      em_reg <= `TSR_EM_RST;
    end else if (ev_gc) begin
      fq_reg <= `TSR_FQ_RST;
      pol_reg <= `TSR_POL_RST;
      tm_reg <= `TSR_TM_RST;
      sd_reg <= `TSR_SD_RST;
      cr_reg <= `TSR_CR_RST;
      em_reg <= `TSR_EM_RST;
    end else if (cfg0_wr) begin
      fq_reg <= cmd_q.data[`TSR_B0_FQ_HI:`TSR_B0_FQ_LO];
      pol_reg <= cmd_q.data[`TSR_B0_POL];
      tm_reg <= cmd_q.data[`TSR_B0_TM];
      sd_reg <= cmd_q.data[`TSR_B0_SD];
    end else if (cfg1_wr) begin
      cr_reg <= cmd_q.data[`TSR_B1_CR_HI:`TSR_B1_CR_LO];
      em_reg <= cmd_q.data[`TSR_B1_EM];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limits, low bits forced to the current format's zeros
  assign lim_mask = em_reg ? `TSR_EXT_MASK : `TSR_NORM_MASK;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      high_reg <= `TSR_HIGH_RST;
      low_reg <= `TSR_LOW_RST;
    end else if (ev_gc) begin
      high_reg <= `TSR_HIGH_RST;
      low_reg <= `TSR_LOW_RST;
    end else if (ev_wr && (cmd_q.sel == `TSR_SEL_HIGH)) begin
      if (!cmd_q.idx) begin
        high_reg[15:8] <= cmd_q.data;
      end else begin
        high_reg[7:0] <= cmd_q.data & lim_mask;
      end
    end else if (ev_wr && (cmd_q.sel == `TSR_SEL_LOW)) begin
      if (!cmd_q.idx) begin
        low_reg[15:8] <= cmd_q.data;
      end else begin
        low_reg[7:0] <= cmd_q.data & lim_mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one-shot request and ready flag; a new request beats a finish
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      os_pend_reg <= 1'b0;
      os_done_reg <= 1'b0;
    end else if (ev_gc) begin
      os_pend_reg <= 1'b0;
      os_done_reg <= 1'b0;
    end else if (os_go) begin
      os_pend_reg <= 1'b1;
      os_done_reg <= 1'b0;
    end else if (conv_end && os_pend_reg) begin
      os_pend_reg <= 1'b0;
      os_done_reg <= 1'b1;
    end
  end

  assign os_bit = os_done_reg && !os_pend_reg;

  ////////////////////////////////////////////////////////////////////////
  // conversion pacing: convert, then idle out the rest of the period
  always_comb begin
    case (cr_reg)
      2'h0: period = PERIOD0;
      2'h1: period = PERIOD1;
      2'h2: period = PERIOD2;
      default: period = PERIOD3;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    start_next = 1'b0;
    case (st_reg)
      TSR_ST_IDLE: begin
        if (os_pend_reg || !sd_reg) begin
          st_next = TSR_ST_CONV;
          start_next = 1'b1;
        end
      end
      TSR_ST_CONV: begin
        // shutdown waits for the running conversion to finish
        if (conv_done_in) begin
          st_next = (sd_reg || os_pend_reg) ? TSR_ST_IDLE
                                             : TSR_ST_WAIT;
        end
      end
      TSR_ST_WAIT: begin
        if (sd_reg) begin
          st_next = TSR_ST_IDLE;
        end else if (per_cnt_reg >= period - 32'h1) begin
          st_next = TSR_ST_CONV;
          start_next = 1'b1;
        end
      end
      default: st_next = TSR_ST_IDLE;
    endcase
  end

  // general call restarts conversion at once, as after power-up
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= TSR_ST_IDLE;
      conv_start_out <= 1'b0;
    end else if (ev_gc) begin
      st_reg <= TSR_ST_CONV;
      conv_start_out <= 1'b1;
    end else begin
      st_reg <= st_next;
      conv_start_out <= start_next;
    end
  end

  // period counter runs from each conversion start, saturating
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      per_cnt_reg <= 32'h0;
    end else if (conv_start_out) begin
      per_cnt_reg <= 32'h1;
    end else if (per_cnt_reg != 32'hffffffff) begin
      per_cnt_reg <= per_cnt_reg + 32'h1;
    end
  end

  assign power_down_out = (st_reg == TSR_ST_IDLE);

  // result store
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      temp_reg <= `TSR_TEMP_RST;
    end else if (ev_gc) begin
      temp_reg <= `TSR_TEMP_RST;
    end else if (conv_end) begin
      temp_reg <= conv_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limit comparison in the current format
  always_comb begin
    if (em_reg) begin
      tval = conv_data_in;
      hval = high_reg[15:3];
      lval = low_reg[15:3];
    end else begin
      tval = {conv_data_in[11], conv_data_in[11:0]};
      hval = {high_reg[15], high_reg[15:4]};
      lval = {low_reg[15], low_reg[15:4]};
    end
  end

  always_comb begin
    case (fq_reg)
      2'h0: need = `TSR_FQ_N0;
      2'h1: need = `TSR_FQ_N1;
      2'h2: need = `TSR_FQ_N2;
      default: need = `TSR_FQ_N3;
    endcase
  end

  // the fault looked for depends on which side of the band we are
  assign fault = cmp_reg ? (tval < lval) : (tval >= hval);
  assign flip = conv_end && fault && ((fcnt_reg + 3'h1) >= need);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fcnt_reg <= 3'h0;
      cmp_reg <= 1'b0;
    end else if (ev_gc) begin
      fcnt_reg <= 3'h0;
      cmp_reg <= 1'b0;
    end else if (flip) begin
      fcnt_reg <= 3'h0;
      cmp_reg <= ~cmp_reg;
    end else if (conv_end) begin
      fcnt_reg <= fault ? fcnt_reg + 3'h1 : 3'h0;
    end
  end

  // interrupt latch: every comparator flip alternates high then low,
  // so setting on each flip gives the required alternation
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      int_reg <= 1'b0;
    end else if (ev_gc) begin
      int_reg <= 1'b0;
    end else if (flip && tm_reg) begin
      int_reg <= 1'b1;
    end else if (ev_rd || ev_ara) begin
      int_reg <= 1'b0;
    end else if (cfg0_wr && cmd_q.data[`TSR_B0_SD]) begin
      int_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // threshold pin: pulled low when active xor polarity
  assign active = tm_reg ? int_reg : cmp_reg;
  assign al_bit = ~(cmp_reg ^ pol_reg);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      alert_oe_reg <= 1'b0;
    end else begin
      alert_oe_reg <= active ^ pol_reg;
    end
  end

  assign alert_oe_out = alert_oe_reg;
  assign alert_o_out = 1'b0; // open drain, only ever pulls low

  ////////////////////////////////////////////////////////////////////////
  // read answers, one byte per request
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ans_send_reg <= 1'b0;
      ans_byte_reg <= 8'h00;
    end else begin
      ans_send_reg <= ev_rd;
      if (ev_rd) begin
        case ({cmd_q.sel, cmd_q.idx})
          {`TSR_SEL_TEMP, 1'b0}:
            ans_byte_reg <= em_reg ? temp_reg[12:5] : temp_reg[11:4];
          {`TSR_SEL_TEMP, 1'b1}:
            ans_byte_reg <= em_reg ? {temp_reg[4:0], `TSR_EXT_PAD}
                                   : {temp_reg[3:0], `TSR_NORM_PAD};
          {`TSR_SEL_CFG, 1'b0}:
            ans_byte_reg <= {os_bit, `TSR_RES_VAL, fq_reg, pol_reg,
                             tm_reg, sd_reg};
          {`TSR_SEL_CFG, 1'b1}:
            ans_byte_reg <= {cr_reg, al_bit, em_reg, `TSR_CFG_PAD};
          {`TSR_SEL_LOW, 1'b0}: ans_byte_reg <= low_reg[15:8];
          {`TSR_SEL_LOW, 1'b1}: ans_byte_reg <= low_reg[7:0];
          {`TSR_SEL_HIGH, 1'b0}: ans_byte_reg <= high_reg[15:8];
          default: ans_byte_reg <= high_reg[7:0];
        endcase
      end
    end
  end
endmodule : tsr_core

// ===== testbench/tsr_core_props.sv
// checker on the temperature sensor core ports
`timescale 1ns/100ps
module tsr_core_props (
  input wire logic clock_in, // core clock
  input wire logic rst_in, // reset
  input wire logic link_clk_in, // link clock
  input wire logic link_rd_in, // read request
  input wire logic link_ready_out, // link free
  input wire logic link_rd_valid_out, // byte pulse
  input wire logic conv_start_out, // start pulse
  input wire logic power_down_out, // idle
  input wire logic alert_o_out, // pin drive
  input wire logic alert_oe_out // pin pull
);
  //////////////////////////////////////////////////////////////////////////
  // core domain: pin drive and conversion pacing
  chk_pin_zero: assert property (
    @(posedge clock_in) disable iff (rst_in) alert_o_out == 1'b0)
    else $error("pin driven high");
  chk_start_gap: assert property (
    @(posedge clock_in) disable iff (rst_in)
    conv_start_out |=> !conv_start_out [*8]) else $error("start too soon");
  chk_start_busy: assert property (
    @(posedge clock_in) disable iff (rst_in)
    conv_start_out |=> !power_down_out) else $error("idle after start");
  chk_wake_cause: assert property (
    @(posedge clock_in) disable iff (rst_in) $fell(power_down_out)
    |-> conv_start_out || $past(conv_start_out)) else $error("woke alone");
  //////////////////////////////////////////////////////////////////////////
  // link domain: read answers
  chk_rd_answer: assert property (
    @(posedge link_clk_in) disable iff (rst_in) link_rd_in && link_ready_out
    |-> ##[2:24] link_rd_valid_out) else $error("read not answered");
  chk_rd_blocks: assert property (
    @(posedge link_clk_in) disable iff (rst_in) link_rd_in && link_ready_out
    |=> !link_ready_out) else $error("ready during read");
  chk_byte_pulse: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    link_rd_valid_out |=> !link_rd_valid_out) else $error("long pulse");
  chk_byte_ready: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    link_rd_valid_out |-> link_ready_out) else $error("busy at byte");
  // main scenarios reached
  cov_alert: cover property (@(posedge clock_in) $rose(alert_oe_out));
  cov_conv: cover property (@(posedge clock_in) conv_start_out);
  cov_read: cover property (@(posedge link_clk_in) link_rd_valid_out);
endmodule : tsr_core_props
bind tsr_core tsr_core_props chk_u (.*);

// ===== testbench/tsr_host_model.sv
// host side model issuing link requests
`timescale 1ns/100ps
module tsr_host_model (
  input wire logic link_clk_in, // link clock
  input wire logic ready_in, // requests taken
  input wire logic rd_valid_in, // byte pulse
  input wire logic [7:0] rd_data_in, // read byte
  output logic [5:0] req_out, // start ptr wr rd gc ara
  output logic [7:0] data_out // byte sent
);
  initial req_out = 6'h00;
  initial data_out = 8'h00;
  // hold a request until ready is seen high at an edge, then drop it
  task automatic req(input int k, input logic [7:0] d);
    @(posedge link_clk_in);
    req_out <= 6'h01 << k;
    data_out <= d;
    #1;
    while (ready_in !== 1'b1) begin
      @(posedge link_clk_in);
      #1;
    end
    @(posedge link_clk_in);
    req_out <= 6'h00;
    data_out <= ~d; // no stale byte left behind
  endtask : req
  // one read byte with a bounded wait for its pulse
  task automatic get(output logic [7:0] b);
    int n;
    req(3, 8'h00);
    for (n = 0; n < 64 && rd_valid_in !== 1'b1; n++) @(posedge link_clk_in) #1;
    b = rd_data_in;
  endtask : get
endmodule : tsr_host_model

// ===== testbench/tsr_core_bench.sv
// bench for the temperature sensor core against a reference model
`timescale 1ns/100ps
`define C(a,b) begin compares++; if ((a)!==(b)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module tsr_core_bench;
  logic clock_in = 0, rst_in = 1, lclk = 0, cdone = 0, pend = 0;
  logic [12:0] cdat = 0, lt = 0;
  logic [5:0] rq;
  logic [7:0] dq, rdd, h, l;
  logic rdy, rdv, cst, pdn, aoe, ao, os, alert_polarity, tm, sd, em, cmp, lat;
  logic [1:0] fq, cr;
  logic [15:0] hw, lw;
  int error_cnt = 0, compares = 0, cnt, cyc = 0, tst = 0, ptst = 0;
  int seed = 32'h19c5;
  int per[4] = '{400, 100, 25, 12};
  //////////////////////////////////////////////////////////////////////////
  // clocks, the link one offset so the phases never line up
  initial forever #5 clock_in = ~clock_in;
  initial #37 forever #40 lclk = ~lclk;
  tsr_core #(.PERIOD0(400), .PERIOD1(100), .PERIOD2(25), .PERIOD3(12))
  dut_u (.clock_in(clock_in), .rst_in(rst_in), .link_clk_in(lclk),
    .link_start_in(rq[0]), .link_ptr_wr_in(rq[1]), .link_wr_in(rq[2]),
    .link_rd_in(rq[3]), .link_gc_in(rq[4]), .link_ara_in(rq[5]),
    .link_data_in(dq), .link_ready_out(rdy), .link_rd_data_out(rdd),
    .link_rd_valid_out(rdv), .conv_start_out(cst), .conv_done_in(cdone),
    .conv_data_in(cdat), .power_down_out(pdn), .alert_o_out(ao),
    .alert_oe_out(aoe));
  tsr_host_model host_u (.link_clk_in(lclk), .ready_in(rdy),
    .rd_valid_in(rdv), .rd_data_in(rdd), .req_out(rq), .data_out(dq));
  // start times feed the rate check; pend marks an open conversion
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cst === 1'b1) begin
      pend <= 1'b1;
      tst <= cyc;
      ptst <= tst;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic int need(logic [1:0] q);
    return q == 0 ? 1 : q == 1 ? 2 : q == 2 ? 4 : 6;
  endfunction : need
  function automatic int lim(logic [15:0] w);
    return em ? int'($signed(w[15:3])) : int'($signed(w[15:4]));
  endfunction : lim
  function automatic logic [15:0] cw();
    return {os, 2'h3, fq, alert_polarity, tm, sd, cr, ~(cmp ^ alert_polarity), em, 4'h0};
  endfunction : cw
  task automatic co();
    `C({ao, aoe}, {1'b0, (tm ? lat : cmp) ^ alert_polarity})
  endtask : co
  // answer one conversion, then step the model and check the pin
  task automatic cv(logic [12:0] t);
    int n, f;
    for (n = 0; n < 900 && pend !== 1'b1; n++) @(posedge clock_in) #1;
    @(posedge clock_in);
    pend <= 1'b0;
    cdone <= 1'b1;
    cdat <= t;
    @(posedge clock_in);
    cdone <= 1'b0;
    repeat (3) @(posedge clock_in);
    lt = t;
    f = cmp ? $signed(t) < lim(lw) : $signed(t) >= lim(hw);
    cnt = f ? cnt + 1 : 0;
    if (cnt >= need(fq)) begin
      cmp = ~cmp;
      cnt = 0;
      lat = tm;
    end
    co();
  endtask : cv
  task automatic cvs(int n, bit up);
    repeat (n) cv(up ? 13'(256 + ($random(seed) & 7))
      : 13'(191 - ($random(seed) & 7)));
  endtask : cvs
  task automatic wrreg(logic [1:0] s, logic [15:0] v);
    host_u.req(0, 8'h00);
    host_u.req(1, {6'h00, s});
    host_u.req(2, v[15:8]);
    host_u.req(2, v[7:0]);
    if (s == 2'h2) lw = v;
    if (s == 2'h3) hw = v;
  endtask : wrreg
  task automatic rdreg(logic [1:0] s, logic [15:0] e);
    host_u.req(1, {6'h00, s});
    host_u.get(h);
    host_u.get(l);
    lat = 1'b0;
    `C({h, l}, e)
  endtask : rdreg
  task automatic wcfg();
    wrreg(2'h1, cw());
    if (sd) lat = 1'b0;
    repeat (40) @(posedge clock_in);
    co();
  endtask : wcfg
  task automatic nost();
    int n;
    n = 0;
    repeat (60) @(posedge clock_in) #1 n += cst;
    `C(n, 0)
  endtask : nost
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // watchdog, well past the expected run length
  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {os, alert_polarity, tm, sd, em, cmp, lat, fq, cr} = 11'h002;
    {hw, lw, cnt} = {16'h5000, 16'h4b00, 32'h0};
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    cv(13'h0123);
    host_u.get(h);
    host_u.get(l);
    `C({h, l}, {lt[11:0], 4'h0})
    rdreg(1, cw());
    rdreg(2, 16'h4b00);
    rdreg(3, 16'h5000);
    $display("reset values done");
    for (int r = 0; r < 4; r++) begin
      cr = r;
      wcfg();
      repeat (3) cv(13'h0100);
      `C(tst - ptst, per[r])
    end
    wrreg(3, 16'h1000);
    wrreg(2, 16'h0c00);
    wrreg(0, 16'hffff);
    rdreg(0, {lt[11:0], 4'h0});
    $display("rates and writes done");
    for (int q = 0; q < 4; q++) begin
      fq = q;
      wcfg();
      cvs(need(fq) - 1, 1);
      cvs(1, 0);
      cvs(need(fq), 1);
      rdreg(1, cw());
      cvs(need(fq), 0);
    end
    {fq, alert_polarity} = 3'h1;
    wcfg();
    cvs(1, 1);
    rdreg(1, cw());
    cvs(1, 0);
    {alert_polarity, em} = 2'h1;
    wcfg();
    cv(13'(400 + ($random(seed) & 31)));
    rdreg(0, {lt, 3'h1});
    $display("fault and format done");
    {em, tm} = 2'h1;
    wcfg();
    cvs(1, 1);
    rdreg(2, 16'h0c00);
    co();
    cvs(1, 1);
    cvs(1, 0);
    host_u.req(5, 8'h00);
    lat = 1'b0;
    repeat (40) @(posedge clock_in);
    co();
    cvs(1, 1);
    sd = 1'b1;
    wcfg();
    cv(13'd224);
    nost();
    `C(pdn, 1'b1)
    os = 1'b1;
    wcfg();
    os = 1'b0;
    rdreg(1, cw());
    cv(13'd224);
    os = 1'b1;
    rdreg(1, cw());
    nost();
    $display("interrupt and shutdown done");
    host_u.req(4, 8'h00);
    {os, alert_polarity, tm, sd, em, cmp, lat, fq, cr} = 11'h002;
    {hw, lw, cnt} = {16'h5000, 16'h4b00, 32'h0};
    repeat (40) @(posedge clock_in);
    co();
    rdreg(1, cw());
    rdreg(3, 16'h5000);
    $display("general call done");
    complete_run();
  end
endmodule : tsr_core_bench
